/* src/hpc_map.svh */
// Purpose: Register offsets, field positions and reset values of the hot-plug config block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: Definitions only; included by hpc_pkg and the design file
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

// Register byte offsets
`define HPC_OFS_CONFIG 12'h408
`define HPC_OFS_POLICY 12'h40C
`define HPC_OFS_STATUS 12'h410

// Field positions in hotplug_config_control
`define HPC_BIT_INV_BUTTON 0
`define HPC_BIT_INV_PRESENCE 1
`define HPC_BIT_INV_FAULT 2
`define HPC_BIT_INV_LATCH 3
`define HPC_BIT_INV_ATTN_LED 4
`define HPC_BIT_INV_PWR_LED 5
`define HPC_BIT_INV_PWR_EN 6
`define HPC_BIT_INV_INTERLOCK 7
`define HPC_BIT_INV_PWR_GOOD 8
`define HPC_SEL_LO 9
`define HPC_SEL_HI 10
`define HPC_BIT_AUTO_OFF 11
`define HPC_CFG_WIDTH 12

// Byte lanes of the policy and status words
`define HPC_POL_LATCH_LSB 0
`define HPC_POL_PWR_CTRL_LSB 16
`define HPC_ST_PRES_LSB 0
`define HPC_ST_LATCH_LSB 8
`define HPC_ST_PWR_LSB 16
`define HPC_ST_AUTO_LSB 24

// Reset values
`define HPC_RST_CONFIG 12'h800
`define HPC_RST_LATCH_CAP 8'h00
`define HPC_RST_PWR_CTRL 8'hFF

`endif

/* src/hpc_pkg.sv */
// Purpose: Types shared by the hot-plug signal configuration block
// Assumes: hpc_map.svh holds every offset, field position and reset value
// Notes: Presence report selector encodings live here as an enum
`include "hpc_map.svh"

package hpc_pkg;

  // Presence report selector settings
  typedef enum logic [1:0] {
    HPC_PRES_BOTH = 2'h0,
    HPC_PRES_SIGNAL = 2'h1,
    HPC_PRES_ALWAYS = 2'h2,
    HPC_PRES_NEVER = 2'h3
  } hpc_pres_e;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } hpc_avl_req_s;

  // Hot-plug input pins of one slot
  typedef struct packed {
    logic button;
    logic presence;
    logic fault;
    logic latch;
    logic power_good;
  } hpc_pin_in_s;

  // Hot-plug output pins of one slot
  typedef struct packed {
    logic attention;
    logic power_led;
    logic power_enable;
    logic interlock;
  } hpc_pin_out_s;

endpackage : hpc_pkg

/* src/hpc_top.sv */
// Purpose: Hot-plug sideband configuration: pin polarity, presence report, latch power-off
// Assumes: 25 MHz clock, synchronous active-low reset, pins synchronous to the clock
// Notes: Corrected signals are active high; a one means asserted (latch one means open)
// Behaviour
// - Invert attention-button input on all ports; reset zero
// - Invert presence-detect input on all ports
// - Invert power-fault input on all ports
// - Invert latch-sensor input on all ports
// - Drive attention-indicator output inverted on all ports
// - Drive power-indicator output inverted on all ports
// - Drive slot power-enable output inverted on all ports
// - Drive interlock output inverted on all ports
// - Invert power-good input on all ports
// - Selector zero reports receiver-detect OR presence
// - Selector one reports presence-detect input only
// - Selector two always reports adapter present
// - Selector three always reports no adapter
// - Latch open cuts slot power when enabled
// - Latch power-off overrides power controller control
`timescale 1ns/100ps
`include "hpc_map.svh"

module hpc_top #(
  parameter int NUM_PORTS = 5 // Downstream slots, at most eight
) (
  input wire logic clock, // Core clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire hpc_pkg::hpc_avl_req_s avl_req, // Avalon-MM request
  output logic [31:0] avl_readdata, // Avalon-MM read data
  output logic avl_waitrequest, // Avalon-MM wait request
  input wire hpc_pkg::hpc_pin_in_s [NUM_PORTS-1:0] pin_in, // Raw slot input pins
  output hpc_pkg::hpc_pin_out_s [NUM_PORTS-1:0] pin_out, // Slot output pins
  input wire logic [NUM_PORTS-1:0] receiver_detect, // Receiver-detect result per port
  input wire logic [NUM_PORTS-1:0] ctrl_attention, // Controller attention indicator on
  input wire logic [NUM_PORTS-1:0] ctrl_power_led, // Controller power indicator on
  input wire logic [NUM_PORTS-1:0] ctrl_interlock, // Controller interlock engaged
  output hpc_pkg::hpc_pin_in_s [NUM_PORTS-1:0] ctrl_in, // Corrected inputs to controllers
  output logic [NUM_PORTS-1:0] ctrl_presence // Reported presence to controllers
);
  import hpc_pkg::*;

  // Register address decode, used by both the read and the write path
  typedef enum logic [1:0] {
    HPC_SEL_NONE,
    HPC_SEL_CONFIG,
    HPC_SEL_POLICY,
    HPC_SEL_STATUS
  } hpc_regsel_e;

  function automatic hpc_regsel_e hpc_decode(input logic [11:0] addr);
    hpc_regsel_e sel;
    sel = HPC_SEL_NONE;
    if (addr == `HPC_OFS_CONFIG) begin
      sel = HPC_SEL_CONFIG;
    end else if (addr == `HPC_OFS_POLICY) begin
      sel = HPC_SEL_POLICY;
    end else if (addr == `HPC_OFS_STATUS) begin
      sel = HPC_SEL_STATUS;
    end
    return sel;
  endfunction : hpc_decode

  // Byte-enable merge of write data into an old register word
  function automatic logic [31:0] hpc_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction : hpc_merge

  // Bus slave state
  logic waitrequest_ff; // High except for the single accept cycle
  logic nxt_waitrequest;
  logic [31:0] readdata_ff; // Read data, valid when waitrequest is low
  logic [31:0] nxt_readdata;

  // Software registers, all held until written and reloaded by reset
  logic [`HPC_CFG_WIDTH-1:0] config_ff; // hotplug_config_control low fields
  logic [`HPC_CFG_WIDTH-1:0] nxt_config;
  logic [NUM_PORTS-1:0] latch_cap_ff; // latch_present_capability per slot
  logic [NUM_PORTS-1:0] nxt_latch_cap;
  logic [NUM_PORTS-1:0] pwr_ctrl_ff; // power_controller_control, one means off
  logic [NUM_PORTS-1:0] nxt_pwr_ctrl;

  // Pin and controller side state
  hpc_pin_out_s [NUM_PORTS-1:0] pin_out_ff; // Registered output pins
  hpc_pin_out_s [NUM_PORTS-1:0] nxt_pin_out;
  hpc_pin_in_s [NUM_PORTS-1:0] ctrl_in_ff; // Corrected inputs to controllers
  hpc_pin_in_s [NUM_PORTS-1:0] nxt_ctrl_in;
  logic [NUM_PORTS-1:0] presence_ff; // Reported presence
  logic [NUM_PORTS-1:0] nxt_presence;
  logic [NUM_PORTS-1:0] power_on_ff; // Logical slot power state
  logic [NUM_PORTS-1:0] nxt_power_on;
  logic [NUM_PORTS-1:0] auto_off_ff; // Latch power-off currently forcing power down
  logic [NUM_PORTS-1:0] nxt_auto_off;

  // Decoded access of the current cycle
  hpc_regsel_e req_sel; // Register hit by the request
  logic wr_take; // Write takes effect at this edge
  logic [31:0] policy_word; // Policy register as read
  logic [31:0] status_word; // Status register as read
  hpc_pres_e pres_mode; // Presence report selector

  assign req_sel = hpc_decode(avl_req.address);
  assign wr_take = avl_req.write && !waitrequest_ff;
  assign pres_mode = hpc_pres_e'(config_ff[`HPC_SEL_HI:`HPC_SEL_LO]);

  // Assemble read images; unused bits read as zero
  always_comb begin
    policy_word = 32'h0000_0000;
    status_word = 32'h0000_0000;
    policy_word[`HPC_POL_LATCH_LSB +: NUM_PORTS] = latch_cap_ff;
    policy_word[`HPC_POL_PWR_CTRL_LSB +: NUM_PORTS] = pwr_ctrl_ff;
    status_word[`HPC_ST_PRES_LSB +: NUM_PORTS] = presence_ff;
    for (int p = 0; p < NUM_PORTS; p++) begin
      status_word[`HPC_ST_LATCH_LSB + p] = ctrl_in_ff[p].latch;
    end
    status_word[`HPC_ST_PWR_LSB +: NUM_PORTS] = power_on_ff;
    status_word[`HPC_ST_AUTO_LSB +: NUM_PORTS] = auto_off_ff;
  end

  // Bus slave: one wait cycle per access, then a single accept cycle.
  // Registering waitrequest costs a cycle but keeps every bus output on a flop.
  always_comb begin
    nxt_waitrequest = 1'b1;
    nxt_readdata = readdata_ff;
    if ((avl_req.read || avl_req.write) && waitrequest_ff) begin
      nxt_waitrequest = 1'b0;
      unique case (req_sel)
        HPC_SEL_CONFIG: nxt_readdata = {{(32-`HPC_CFG_WIDTH){1'b0}}, config_ff};
        HPC_SEL_POLICY: nxt_readdata = policy_word;
        HPC_SEL_STATUS: nxt_readdata = status_word;
        HPC_SEL_NONE: nxt_readdata = 32'h0000_0000; // Unmapped reads give zero
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else begin
      waitrequest_ff <= nxt_waitrequest;
      readdata_ff <= nxt_readdata;
    end
  end

  // Register writes; status is read only and unmapped writes are dropped
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    nxt_config = config_ff;
    nxt_latch_cap = latch_cap_ff;
    nxt_pwr_ctrl = pwr_ctrl_ff;
    if (wr_take && req_sel == HPC_SEL_CONFIG) begin
      merged = hpc_merge({{(32-`HPC_CFG_WIDTH){1'b0}}, config_ff},
                         avl_req.writedata, avl_req.byteenable);
      nxt_config = merged[`HPC_CFG_WIDTH-1:0];
    end else if (wr_take && req_sel == HPC_SEL_POLICY) begin
      merged = hpc_merge(policy_word, avl_req.writedata, avl_req.byteenable);
      nxt_latch_cap = merged[`HPC_POL_LATCH_LSB +: NUM_PORTS];
      nxt_pwr_ctrl = merged[`HPC_POL_PWR_CTRL_LSB +: NUM_PORTS];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config_ff <= `HPC_RST_CONFIG;
      latch_cap_ff <= NUM_PORTS'(`HPC_RST_LATCH_CAP);
      pwr_ctrl_ff <= NUM_PORTS'(`HPC_RST_PWR_CTRL);
    end else begin
      config_ff <= nxt_config;
      latch_cap_ff <= nxt_latch_cap;
      pwr_ctrl_ff <= nxt_pwr_ctrl;
    end
  end

  // Per-slot signal path. Inputs are corrected once at the pins so that
  // presence, latch power-off and the controllers never see raw sense.
  always_comb begin
    hpc_pin_in_s fixed;
    logic want_on;
    fixed = '0;
    want_on = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Pin boundary correction
      fixed.button = pin_in[p].button ^ config_ff[`HPC_BIT_INV_BUTTON];
      fixed.presence = pin_in[p].presence ^ config_ff[`HPC_BIT_INV_PRESENCE];
      fixed.fault = pin_in[p].fault ^ config_ff[`HPC_BIT_INV_FAULT];
      fixed.latch = pin_in[p].latch ^ config_ff[`HPC_BIT_INV_LATCH];
      fixed.power_good = pin_in[p].power_good ^ config_ff[`HPC_BIT_INV_PWR_GOOD];
      nxt_ctrl_in[p] = fixed;
      // Presence report to the controller
      unique case (pres_mode)
        HPC_PRES_BOTH: nxt_presence[p] = receiver_detect[p] | fixed.presence;
        HPC_PRES_SIGNAL: nxt_presence[p] = fixed.presence;
        HPC_PRES_ALWAYS: nxt_presence[p] = 1'b1;
        HPC_PRES_NEVER: nxt_presence[p] = 1'b0;
      endcase
      // With auto-off set, an open latch on a latch-capable slot forces power off whatever the power controller bit asks
      nxt_auto_off[p] = config_ff[`HPC_BIT_AUTO_OFF] && latch_cap_ff[p] && fixed.latch;
      want_on = !pwr_ctrl_ff[p];
      nxt_power_on[p] = want_on && !nxt_auto_off[p];
      // Output pin polarity
      nxt_pin_out[p].attention = ctrl_attention[p] ^ config_ff[`HPC_BIT_INV_ATTN_LED];
      nxt_pin_out[p].power_led = ctrl_power_led[p] ^ config_ff[`HPC_BIT_INV_PWR_LED];
      nxt_pin_out[p].power_enable = nxt_power_on[p] ^ config_ff[`HPC_BIT_INV_PWR_EN];
      nxt_pin_out[p].interlock = ctrl_interlock[p] ^ config_ff[`HPC_BIT_INV_INTERLOCK];
    end
  end

  // Slot side registers; power stays off through reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out_ff <= '0;
      ctrl_in_ff <= '0;
      presence_ff <= '0;
      power_on_ff <= '0;
      auto_off_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      ctrl_in_ff <= nxt_ctrl_in;
      presence_ff <= nxt_presence;
      power_on_ff <= nxt_power_on;
      auto_off_ff <= nxt_auto_off;
    end
  end

  assign avl_readdata = readdata_ff;
  assign avl_waitrequest = waitrequest_ff;
  assign pin_out = pin_out_ff;
  assign ctrl_in = ctrl_in_ff;
  assign ctrl_presence = presence_ff;

  // Checks, all on the core clock
  default clocking hpc_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Helper vectors, one bit per port, of slot pin fields
  logic [NUM_PORTS-1:0] raw_button; // Raw button pins
  logic [NUM_PORTS-1:0] raw_presence; // Raw presence pins
  logic [NUM_PORTS-1:0] raw_latch; // Raw latch pins
  logic [NUM_PORTS-1:0] out_pwr_en; // Power-enable pins
  logic [NUM_PORTS-1:0] in_button; // Corrected button to controllers
  logic [NUM_PORTS-1:0] in_presence; // Corrected presence
  logic [NUM_PORTS-1:0] out_attn; // Attention pins
  logic [NUM_PORTS-1:0] fix_presence; // Presence pins after polarity fix

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      raw_button[p] = pin_in[p].button;
      raw_presence[p] = pin_in[p].presence;
      raw_latch[p] = pin_in[p].latch;
      out_pwr_en[p] = pin_out_ff[p].power_enable;
      in_button[p] = ctrl_in_ff[p].button;
      in_presence[p] = ctrl_in_ff[p].presence;
      out_attn[p] = pin_out_ff[p].attention;
      // Kept as a signal so assertions sample it, not a live function value
      fix_presence[p] = pin_in[p].presence ^ config_ff[`HPC_BIT_INV_PRESENCE];
    end
  end

  // Bus access steps
  sequence s_req_wait;
    (avl_req.read || avl_req.write) && waitrequest_ff;
  endsequence

  sequence s_cfg_full_write;
    avl_req.write && !waitrequest_ff && req_sel == HPC_SEL_CONFIG && avl_req.byteenable == 4'hF;
  endsequence

  AST_RESET_CONFIG: assert property (disable iff (1'b0) !rst_n |=>
    config_ff == `HPC_RST_CONFIG && waitrequest_ff) else $error("config reset value wrong");

  AST_WAIT_ONE: assert property (s_req_wait |=> !waitrequest_ff ##1 waitrequest_ff)
    else $error("waitrequest not one accept cycle");

  AST_CFG_WRITE: assert property (s_cfg_full_write |=>
    config_ff == $past(avl_req.writedata[`HPC_CFG_WIDTH-1:0])) else $error("config write lost");

  AST_BUTTON_INV: assert property (1'b1 |=>
    in_button == ($past(raw_button) ^ {NUM_PORTS{$past(config_ff[`HPC_BIT_INV_BUTTON])}}))
    else $error("button sense wrong");

  AST_PRES_INV: assert property (1'b1 |=>
    in_presence == ($past(raw_presence) ^ {NUM_PORTS{$past(config_ff[`HPC_BIT_INV_PRESENCE])}}))
    else $error("presence sense wrong");

  AST_ATTN_INV: assert property (1'b1 |=>
    out_attn == ($past(ctrl_attention) ^ {NUM_PORTS{$past(config_ff[`HPC_BIT_INV_ATTN_LED])}}))
    else $error("attention pin sense wrong");

  AST_PRES_BOTH: assert property (pres_mode == HPC_PRES_BOTH |=>
    presence_ff == ($past(receiver_detect) | $past(fix_presence)))
    else $error("combined presence wrong");

  AST_PRES_SIGNAL: assert property (pres_mode == HPC_PRES_SIGNAL |=>
    presence_ff == $past(fix_presence)) else $error("signal presence wrong");

  AST_PRES_ALWAYS: assert property (pres_mode == HPC_PRES_ALWAYS |=>
    presence_ff == {NUM_PORTS{1'b1}}) else $error("always presence wrong");

  AST_PRES_NEVER: assert property (pres_mode == HPC_PRES_NEVER |=>
    presence_ff == {NUM_PORTS{1'b0}}) else $error("never presence wrong");

  AST_AUTO_OFF: assert property (config_ff[`HPC_BIT_AUTO_OFF] && latch_cap_ff[0]
    && (raw_latch[0] ^ config_ff[`HPC_BIT_INV_LATCH]) |=> auto_off_ff[0] && !power_on_ff[0])
    else $error("latch power-off missed");

  AST_LATCH_OVERRIDE: assert property (auto_off_ff[0] |->
    !power_on_ff[0] && out_pwr_en[0] == $past(config_ff[`HPC_BIT_INV_PWR_EN]))
    else $error("power on while latch open");

endmodule : hpc_top

/* test/hpc_slot_model.sv */
// Purpose: Model of the slot side: buttons, sensors and supply pins of each slot
// Assumes: Pin levels follow the bench's wishes one edge later, as a settled sensor would
// Notes: Pins are plain levels with no pull; the model leaves them unknown only until the first edge
`timescale 1ns/100ps

module hpc_slot_model #(
  parameter int NUM_PORTS = 2 // Slots modelled
) (
  input wire logic clock, // Core clock
  input wire hpc_pkg::hpc_pin_in_s [NUM_PORTS-1:0] level, // Pin levels wanted next
  output hpc_pkg::hpc_pin_in_s [NUM_PORTS-1:0] pin_in // Pins seen by the device
);
  import hpc_pkg::*;

  // Sensors change just after an edge, never at the sampling instant.
  // One driver only; pins are unknown until the first edge, inside reset.
  always @(posedge clock) begin
    pin_in <= level;
  end
endmodule : hpc_slot_model

/* test/hpc_top_test.sv */
// Purpose: Self-checking bench of the hot-plug signal configuration block
// Assumes: Two slots; expectations worked out here from the pin polarity and select rules
// Notes: Every config setting is crossed with four pin patterns, before and after power is on
`timescale 1ns/100ps
`include "hpc_map.svh"

module hpc_top_test;
  import hpc_pkg::*;

  localparam int NP = 2; // Two slots keep the tables short
  localparam int LIMIT = 6000; // Cycle ceiling, several times the expected run
  logic clock = 1'b0; // Core clock, 25 MHz
  logic rst_n = 1'b0; // Reset, active low
  hpc_avl_req_s req = '0; // Bus request
  logic [31:0] rdata; // Read data
  logic wait_req; // Wait request
  hpc_pin_in_s [NP-1:0] level = '0; // Wanted pin levels
  hpc_pin_in_s [NP-1:0] pins; // Pins at the device
  hpc_pin_out_s [NP-1:0] pout; // Slot outputs
  hpc_pin_in_s [NP-1:0] cin; // Corrected inputs
  logic [NP-1:0] cpres; // Reported presence
  logic [NP-1:0] rdet = '0; // Receiver detect
  logic [NP-1:0] c_att = '0; // Attention command
  logic [NP-1:0] c_pled = '0; // Power indicator command
  logic [NP-1:0] c_ilk = '0; // Interlock command
  logic [11:0] cfg; // Config value the bench believes
  logic [7:0] cap; // Latch present per slot
  logic [7:0] pwr_off; // Power off request per slot
  logic [9:0] pats [4] = '{10'h000, 10'h3FF, 10'h2B5, 10'h14A}; // Pin patterns
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  // 40 ns period
  always #20 clock = ~clock;

  hpc_slot_model #(.NUM_PORTS(NP)) slots (.clock(clock), .level(level), .pin_in(pins));

  hpc_top #(.NUM_PORTS(NP)) dut (
    .clock(clock), .rst_n(rst_n), .avl_req(req), .avl_readdata(rdata),
    .avl_waitrequest(wait_req), .pin_in(pins), .pin_out(pout), .receiver_detect(rdet),
    .ctrl_attention(c_att), .ctrl_power_led(c_pled), .ctrl_interlock(c_ilk),
    .ctrl_in(cin), .ctrl_presence(cpres)
  );

  // Verdict and end of run, reached from the main flow or the timeout
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Case-equality compare, so an unknown never passes
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One Avalon access; held until waitrequest is sampled low, released after
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    do @(posedge clock); while (wait_req !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  // Read a register and compare it
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd_chk

  // Work out every slot output from the bench's own state and compare
  task automatic check_slots();
    hpc_pin_in_s [NP-1:0] ec;
    hpc_pin_out_s [NP-1:0] eo;
    logic [NP-1:0] ep;
    logic [NP-1:0] el;
    logic [NP-1:0] en;
    logic [NP-1:0] ea;
    for (int p = 0; p < NP; p++) begin
      ec[p].button = level[p].button ^ cfg[0];
      ec[p].presence = level[p].presence ^ cfg[1];
      ec[p].fault = level[p].fault ^ cfg[2];
      ec[p].latch = level[p].latch ^ cfg[3];
      ec[p].power_good = level[p].power_good ^ cfg[8];
      el[p] = ec[p].latch;
      case (cfg[10:9])
        2'h0: ep[p] = rdet[p] | ec[p].presence;
        2'h1: ep[p] = ec[p].presence;
        2'h2: ep[p] = 1'b1;
        default: ep[p] = 1'b0;
      endcase
      ea[p] = cfg[11] & cap[p] & ec[p].latch;
      en[p] = !pwr_off[p] & !ea[p];
      eo[p].attention = c_att[p] ^ cfg[4];
      eo[p].power_led = c_pled[p] ^ cfg[5];
      eo[p].power_enable = en[p] ^ cfg[6];
      eo[p].interlock = c_ilk[p] ^ cfg[7];
    end
    chk("corrected inputs", 32'(ec), 32'(cin));
    chk("presence report", 32'(ep), 32'(cpres));
    chk("slot outputs", 32'(eo), 32'(pout));
    rd_chk("status", `HPC_OFS_STATUS, {8'(ea), 8'(en), 8'(el), 8'(ep)});
  endtask : check_slots

  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end

  // Main sequence: reset values, then each setting crossed with pin patterns
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    cfg = 12'h800;
    cap = 8'h00;
    pwr_off = 8'hFF;
    rd_chk("config reset", `HPC_OFS_CONFIG, 32'h0000_0800);
    // Only the implemented slots hold a power-off bit; the rest read zero
    rd_chk("policy reset", `HPC_OFS_POLICY, {8'h00, 8'(pwr_off[NP-1:0]), 16'h0000});
    rd_chk("unmapped read", 12'h500, 32'h0000_0000);
    for (int ph = 0; ph < 2; ph++) begin
      // Second pass: slot 0 has a latch and power is requested on all slots
      if (ph == 1) begin
        cap = 8'h01;
        pwr_off = 8'h00;
        bus(1'b1, `HPC_OFS_POLICY, 32'h0000_0001, q);
        rd_chk("policy", `HPC_OFS_POLICY, 32'h0000_0001);
        bus(1'b1, `HPC_OFS_STATUS, 32'hFFFF_FFFF, q);
      end
      for (int c = 0; c < 14; c++) begin
        // Each invert bit alone, each selector value, auto-off cleared, all inverts
        if (c < 9) cfg = 12'h800 | (12'h001 << c);
        else if (c < 12) cfg = 12'h800 | (12'(c - 8) << 9);
        else if (c == 12) cfg = 12'h008;
        else cfg = 12'h1FF;
        bus(1'b1, `HPC_OFS_CONFIG, {20'hF_FFFF, cfg}, q);
        rd_chk("config", `HPC_OFS_CONFIG, {20'h0_0000, cfg});
        for (int s = 0; s < 4; s++) begin
          level <= pats[s];
          rdet <= 2'(s);
          c_att <= 2'(s + 1);
          c_pled <= 2'(s + 2);
          c_ilk <= 2'(s + 3);
          // Model edge, design edge, then one to spare
          repeat (3) @(posedge clock);
          check_slots();
        end
      end
    end
    wrap_up();
  end
endmodule : hpc_top_test
